// ---- rtl/prr_pkg.sv ----
package prr_pkg;
  // bits-per-pixel codes
  localparam logic [1:0] BPP_1 = 2'h0;
  localparam logic [1:0] BPP_2 = 2'h1;
  localparam logic [1:0] BPP_4 = 2'h2;
  localparam logic [1:0] BPP_8 = 2'h3;
  // pixel clock select codes
  localparam logic [1:0] PCS_DIV1 = 2'h0;
  localparam logic [1:0] PCS_DIV2 = 2'h1;
  localparam logic [1:0] PCS_DIV4 = 2'h2;
  localparam logic [1:0] PCS_DIV8 = 2'h3;
  // stride code zero stands for a full 256-byte stride
  localparam logic [7:0] STRIDE_ZERO_CODE = 8'h00;
  localparam logic [8:0] STRIDE_FULL = 9'h100;
  localparam int ADDR_W = 17;
  localparam logic [16:0] ADDR_RESET = 17'h00000;
  localparam logic [7:0] PIXEL_RESET = 8'h00;
  localparam logic [2:0] DIV_RESET = 3'h0;
  typedef enum logic [1:0] {PRR_IDLE, PRR_RUN} prr_state_t;
endpackage

// ---- rtl/prr_lut.sv ----
`timescale 1ns/1ns
`default_nettype none
// 256-entry colour look-up memory, one per colour channel
module prr_lut #(
  parameter int DW = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [7:0] wr_idx_in,
  input wire logic [DW-1:0] wr_data_in,
  // read port
  input wire logic [7:0] rd_idx_in,
  output logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem [0:255];
  logic [DW-1:0] rd_data_ff;

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_idx_in];
    end
  end

  assign rd_data_out = rd_data_ff;
endmodule
`default_nettype wire

// ---- rtl/prr_refresh.sv ----
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE_01 - video inversion is applied to look-up output, never to its input
// RULE_02 - monochrome modes route every pixel through the green table only
// RULE_03 - host lays out default-mode rotated image with power-of-two width
// RULE_04 - host prefers default mode when its virtual image fits the buffer
// RULE_05 - default mode needs memory clock at least pixel clock
// RULE_06 - rotated refresh scans corners B, D, A, C of the written frame
// RULE_07 - refresh starts at start address; host loads corner B there
// RULE_08 - host sets default-mode stride to virtual image width in bytes
// RULE_09 - start address plus one pans image one byte horizontally
// RULE_10 - default mode pans vertically only in two-line steps
// RULE_11 - alternate mode needs memory clock twice the pixel clock
// RULE_12 - host sets alternate-mode stride to actual image width
// RULE_13 - alternate mode: adding stride to start pans one line
// RULE_14 - alternate mode pixel clock at most 12.5MHz from 25MHz input
// RULE_15 - split screen is disabled while any rotation mode is active
// RULE_16 - enable bit selects rotation; select bit picks default or alternate
// RULE_17 - stride code zero means 256 bytes, otherwise n bytes
// RULE_18 - two-bit select divides pixel and memory clocks per rotation mode
// RULE_19 - address steps by stride along a line, back one pixel per line
module prr_refresh #(
  parameter int LINE_PIX_W = 10,
  parameter int LINES_W = 10
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic rot_enable_in,
  input wire logic rot_select_in,
  input wire logic [1:0] pclk_sel_in,
  input wire logic [7:0] line_byte_count_in,
  input wire logic [prr_pkg::ADDR_W-1:0] start_addr_in,
  input wire logic [LINE_PIX_W-1:0] line_pixels_in,
  input wire logic [LINES_W-1:0] frame_lines_in,
  input wire logic [1:0] bpp_in,
  input wire logic color_mode_in,
  input wire logic invert_in,
  input wire logic split_req_in,
  // frame control
  input wire logic frame_start_in,
  // look-up table load
  input wire logic lut_wr_en_in,
  input wire logic [1:0] lut_wr_sel_in,
  input wire logic [7:0] lut_wr_idx_in,
  input wire logic [3:0] lut_wr_data_in,
  // display buffer read
  output logic [prr_pkg::ADDR_W-1:0] mem_addr_out,
  output logic mem_rd_out,
  input wire logic [7:0] mem_data_in,
  // pixel output
  output logic [11:0] pixel_out,
  output logic pixel_valid_out,
  output logic pclk_en_out,
  output logic mclk_en_out,
  output logic split_active_out,
  output logic busy_out
);
  // ---------------------------------------------
  // mode and clock ratio decode
  // ---------------------------------------------
  wire rot_default = rot_enable_in && !rot_select_in; // RULE_16
  wire rot_alt = rot_enable_in && rot_select_in; // RULE_16
  assign split_active_out = split_req_in && !rot_enable_in; // RULE_15

  logic [2:0] div_ff;
  wire [2:0] pclk_mask = (pclk_sel_in == prr_pkg::PCS_DIV1) ? 3'h0 :
                         (pclk_sel_in == prr_pkg::PCS_DIV2) ? 3'h1 :
                         (pclk_sel_in == prr_pkg::PCS_DIV4) ? 3'h3 : 3'h7;
  // alternate mode: memory runs twice pixel rate; code 00 gives the same clk/2, clk as code 01
  wire [2:0] alt_pmask = (pclk_sel_in == prr_pkg::PCS_DIV1) ? 3'h1 : pclk_mask;
  wire [2:0] alt_mmask = (pclk_sel_in == prr_pkg::PCS_DIV1) ? 3'h0 : {1'b0, pclk_mask[2:1]};
  wire [2:0] pmask = rot_alt ? alt_pmask : (rot_default ? pclk_mask : 3'h0); // RULE_18
  wire [2:0] mmask = rot_alt ? alt_mmask : pmask; // RULE_18
  wire pclk_tick = (div_ff & pmask) == 3'h0;
  wire mclk_tick = (div_ff & mmask) == 3'h0;
  assign pclk_en_out = pclk_tick;
  assign mclk_en_out = mclk_tick;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_ff <= prr_pkg::DIV_RESET;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  // ---------------------------------------------
  // rotated address generator
  // ---------------------------------------------
  // stride code 00 stands for a full 256 bytes
  wire [8:0] stride = (line_byte_count_in == prr_pkg::STRIDE_ZERO_CODE) ?
                      prr_pkg::STRIDE_FULL : {1'b0, line_byte_count_in}; // RULE_17
  // pixels per byte; a column step moves back one byte every ppb lines
  wire [3:0] ppb = (bpp_in == prr_pkg::BPP_1) ? 4'h8 :
                   (bpp_in == prr_pkg::BPP_2) ? 4'h4 :
                   (bpp_in == prr_pkg::BPP_4) ? 4'h2 : 4'h1;

  prr_pkg::prr_state_t state_ff, nxt_state;
  logic [prr_pkg::ADDR_W-1:0] line_base_ff, addr_ff;
  logic [LINE_PIX_W-1:0] pix_cnt_ff;
  logic [LINES_W-1:0] line_cnt_ff;
  logic [2:0] sub_ff; // pixel position inside the byte for this column
  logic [2:0] rd_sub_ff;
  logic rd_pend_ff, out_pend_ff;

  wire step = (state_ff == prr_pkg::PRR_RUN) && pclk_tick;
  wire line_end = pix_cnt_ff == line_pixels_in;
  wire frame_end = line_end && (line_cnt_ff == frame_lines_in);
  wire sub_last = ({1'b0, sub_ff} == ppb - 4'h1);
  wire [prr_pkg::ADDR_W-1:0] stride_ext = {{(prr_pkg::ADDR_W-9){1'b0}}, stride};
  // next column steps one pixel back toward corner A, corner order B-D-A-C
  wire [prr_pkg::ADDR_W-1:0] nxt_base = sub_last ?
      line_base_ff - {{(prr_pkg::ADDR_W-1){1'b0}}, 1'b1} : line_base_ff; // RULE_06 RULE_19

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      prr_pkg::PRR_IDLE: if (frame_start_in && rot_enable_in) nxt_state = prr_pkg::PRR_RUN;
      prr_pkg::PRR_RUN: if ((step && frame_end) || !rot_enable_in) nxt_state = prr_pkg::PRR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= prr_pkg::PRR_IDLE;
      line_base_ff <= prr_pkg::ADDR_RESET;
      addr_ff <= prr_pkg::ADDR_RESET;
      pix_cnt_ff <= '0;
      line_cnt_ff <= '0;
      sub_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == prr_pkg::PRR_IDLE) begin
        // start address is corner B; panning is done purely by moving it
        line_base_ff <= start_addr_in; // RULE_07 RULE_09 RULE_10 RULE_13
        addr_ff <= start_addr_in; // RULE_07
        pix_cnt_ff <= '0;
        line_cnt_ff <= '0;
        sub_ff <= '0;
      end else if (step) begin
        if (line_end) begin
          pix_cnt_ff <= '0;
          line_cnt_ff <= line_cnt_ff + 1'b1;
          line_base_ff <= nxt_base; // RULE_19
          addr_ff <= nxt_base;
          sub_ff <= sub_last ? 3'h0 : sub_ff + 3'h1;
        end else begin
          pix_cnt_ff <= pix_cnt_ff + 1'b1;
          addr_ff <= addr_ff + stride_ext; // RULE_19
        end
      end
    end
  end

  assign mem_addr_out = addr_ff;
  assign mem_rd_out = step;
  assign busy_out = state_ff == prr_pkg::PRR_RUN;

  // ---------------------------------------------
  // pixel extraction
  // ---------------------------------------------
  // buffer data arrives registered; a second stage here would split it from its sub-position
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pend_ff <= 1'b0;
      out_pend_ff <= 1'b0;
      rd_sub_ff <= '0;
    end else begin
      rd_pend_ff <= step;
      rd_sub_ff <= sub_ff;
      out_pend_ff <= rd_pend_ff;
    end
  end

  // leftmost pixel sits in the most significant bits of the byte
  logic [7:0] lut_idx;
  always_comb begin
    lut_idx = prr_pkg::PIXEL_RESET;
    unique case (bpp_in)
      prr_pkg::BPP_1: lut_idx = {7'h00, mem_data_in[3'h7 - rd_sub_ff]};
      prr_pkg::BPP_2: lut_idx = {6'h00, mem_data_in[(3'h3 - {1'b0, rd_sub_ff[1:0]}) * 2 +: 2]};
      prr_pkg::BPP_4: lut_idx = {4'h0, rd_sub_ff[0] ? mem_data_in[3:0] : mem_data_in[7:4]};
      prr_pkg::BPP_8: lut_idx = mem_data_in;
    endcase
  end

  // ---------------------------------------------
  // look-up and inversion
  // ---------------------------------------------
  logic [3:0] red_q, green_q, blue_q;
  prr_lut #(.DW(4)) u_red (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .wr_en_in(lut_wr_en_in && lut_wr_sel_in == 2'h0), .wr_idx_in(lut_wr_idx_in),
    .wr_data_in(lut_wr_data_in), .rd_idx_in(lut_idx), .rd_data_out(red_q));
  prr_lut #(.DW(4)) u_green (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .wr_en_in(lut_wr_en_in && lut_wr_sel_in == 2'h1), .wr_idx_in(lut_wr_idx_in),
    .wr_data_in(lut_wr_data_in), .rd_idx_in(lut_idx), .rd_data_out(green_q));
  prr_lut #(.DW(4)) u_blue (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .wr_en_in(lut_wr_en_in && lut_wr_sel_in == 2'h2), .wr_idx_in(lut_wr_idx_in),
    .wr_data_in(lut_wr_data_in), .rd_idx_in(lut_idx), .rd_data_out(blue_q));

  // monochrome drives green on all three channels
  wire [11:0] lut_rgb = color_mode_in ? {red_q, green_q, blue_q} :
                        {green_q, green_q, green_q}; // RULE_02
  wire [11:0] shown = invert_in ? ~lut_rgb : lut_rgb; // RULE_01

  logic [11:0] pixel_ff;
  logic valid_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pixel_ff <= 12'h000;
      valid_ff <= 1'b0;
    end else begin
      pixel_ff <= shown;
      valid_ff <= out_pend_ff;
    end
  end

  assign pixel_out = pixel_ff;
  assign pixel_valid_out = valid_ff;
endmodule
`default_nettype wire

// ---- verif/prr_refresh_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module prr_refresh_sva (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rot_enable_in,
  input wire logic rot_select_in,
  input wire logic [1:0] pclk_sel_in,
  input wire logic [prr_pkg::ADDR_W-1:0] start_addr_in,
  input wire logic split_req_in,
  input wire logic frame_start_in,
  input wire logic [prr_pkg::ADDR_W-1:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic pixel_valid_out,
  input wire logic pclk_en_out,
  input wire logic mclk_en_out,
  input wire logic split_active_out,
  input wire logic busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire alt = rot_enable_in && rot_select_in;
  chk_split_off: assert property (split_active_out == (split_req_in && !rot_enable_in))
    else $error("split active in rotation");
  chk_start_addr: assert property (frame_start_in && rot_enable_in && !busy_out
    |=> busy_out && mem_addr_out == $past(start_addr_in)) else $error("bad first address");
  chk_read_pipe: assert property (mem_rd_out |-> ##3 pixel_valid_out)
    else $error("pixel missing after read");
  chk_valid_cause: assert property (pixel_valid_out |-> $past(mem_rd_out, 3))
    else $error("pixel without read");
  chk_rd_on_pclk: assert property (mem_rd_out |-> pclk_en_out && busy_out)
    else $error("read off pixel clock");
  chk_abort_idle: assert property (!rot_enable_in |=> !busy_out)
    else $error("busy without rotation");
  chk_dflt_mclk: assert property (rot_enable_in && !rot_select_in |-> mclk_en_out == pclk_en_out)
    else $error("default clocks differ");
  chk_alt_mclk: assert property (alt && pclk_sel_in == prr_pkg::PCS_DIV1 |-> mclk_en_out)
    else $error("alternate memory clock slow");
  chk_div_two: assert property (busy_out && pclk_sel_in == prr_pkg::PCS_DIV2 && pclk_en_out
    |=> !pclk_en_out) else $error("divide by two broken");
endmodule
`default_nettype wire

// ---- verif/prr_buf_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// display buffer: answers each read on the next edge, as fast as any clock ratio allows
module prr_buf_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic mem_rd_in,
  input wire logic [prr_pkg::ADDR_W-1:0] mem_addr_in,
  output logic [7:0] mem_data_out
);
  logic [7:0] q_ff;
  assign mem_data_out = q_ff;
  // between reads the data toggles so a sample one cycle late never sees a stale byte
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= 8'h00;
    end else if (mem_rd_in) begin
      q_ff <= mem_addr_in[7:0] ^ {6'h0, mem_addr_in[9:8]} ^ 8'h3c;
    end else begin
      q_ff <= ~q_ff;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_prr_refresh.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_prr_refresh;
  logic clk_in = 1'b0, rst_n_in = 1'b0, en = 1'b0, sel = 1'b0, inv = 1'b0, col = 1'b0;
  logic spl = 1'b0, fs = 1'b0, lwe = 1'b0, rd, pv, pen, men, sact, busy;
  logic [1:0] lsel = 2'h0, pcs = 2'h0, bpp = 2'h0;
  logic [7:0] lidx = 8'h00, lbc = 8'h00, md;
  logic [3:0] ldat = 4'h0;
  logic [16:0] st = 17'h00000, ma;
  logic [11:0] pix;
  logic [16:0] aq[$];
  logic [11:0] pq[$];
  int fails = 0, num_checks = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  prr_refresh dut (.clk_in, .rst_n_in, .rot_enable_in(en), .rot_select_in(sel),
    .pclk_sel_in(pcs), .line_byte_count_in(lbc), .start_addr_in(st),
    .line_pixels_in(10'h002), .frame_lines_in(10'h002), .bpp_in(bpp), .color_mode_in(col),
    .invert_in(inv), .split_req_in(spl), .frame_start_in(fs), .lut_wr_en_in(lwe),
    .lut_wr_sel_in(lsel), .lut_wr_idx_in(lidx), .lut_wr_data_in(ldat), .mem_addr_out(ma),
    .mem_rd_out(rd), .mem_data_in(md), .pixel_out(pix), .pixel_valid_out(pv),
    .pclk_en_out(pen), .mclk_en_out(men), .split_active_out(sact), .busy_out(busy));
  prr_buf_model mem (.clk_in, .rst_n_in, .mem_rd_in(rd), .mem_addr_in(ma), .mem_data_out(md));
  task end_sim;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // sampled off the active edge so settled outputs are seen
  always @(negedge clk_in) begin
    cyc <= cyc + 1;
    if (rd) aq.push_back(ma);
    if (pv) pq.push_back(pix);
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task cmp_a(input logic [16:0] g, input logic [16:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t address %h want %h", $time, g, e);
    end
  endtask
  task cmp_p(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t pixel %h want %h", $time, g, e);
    end
  endtask
  task cmp_b(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t flag %b want %b", $time, g, e);
    end
  endtask
  // green table contents are chosen so inverting before or after the lookup differs
  function automatic logic [3:0] lutv(input logic [1:0] s, input logic [7:0] i);
    case (s)
      2'h0: return i[7:4];
      2'h1: return i[3:0] + 4'h1;
      default: return i[3:0] ^ 4'h5;
    endcase
  endfunction
  task frame(input logic s, input logic [1:0] pc, input logic [7:0] lb, input logic [16:0] a,
             input logic [1:0] bp, input logic c, input logic iv);
    int ppb, str, k, n;
    logic [16:0] ea;
    logic [7:0] b, ix;
    logic [11:0] ep;
    @(negedge clk_in);
    {sel, pcs, lbc, st, bpp, col, inv} = {s, pc, lb, a, bp, c, iv};
    aq.delete();
    pq.delete();
    @(negedge clk_in);
    fs = 1'b1;
    // the second start edge lands while busy and must be ignored
    repeat (2) @(negedge clk_in);
    fs = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk_in);
      n++;
    end
    repeat (4) @(negedge clk_in);
    ppb = 8 >> bp;
    str = (lb == 8'h00) ? 256 : int'(lb);
    cmp_a(17'(aq.size()), 17'h9);
    cmp_a(17'(pq.size()), 17'h9);
    for (int l = 0; l < 3; l++) begin
      for (int p = 0; p < 3; p++) begin
        k = l * 3 + p;
        ea = 17'(a + p * str - l / ppb);
        b = ea[7:0] ^ {6'h0, ea[9:8]} ^ 8'h3c;
        ix = 8'((b >> ((ppb - 1 - l % ppb) << bp)) & ((1 << (1 << bp)) - 1));
        ep = c ? {lutv(2'h0, ix), lutv(2'h1, ix), lutv(2'h2, ix)} : {3{lutv(2'h1, ix)}};
        if (iv) ep = ~ep;
        if (k < aq.size()) cmp_a(aq[k], ea);
        if (k < pq.size()) cmp_p(pq[k], ep);
      end
    end
  endtask
  initial begin
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    spl = 1'b1;
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 256; i++) begin
        @(negedge clk_in);
        {lwe, lsel, lidx, ldat} = {1'b1, 2'(s), 8'(i), lutv(2'(s), 8'(i))};
      end
    end
    @(negedge clk_in);
    cmp_b(sact, 1'b1);
    lwe = 1'b0;
    en = 1'b1;
    frame(1'b0, prr_pkg::PCS_DIV1, 8'h00, 17'h000ef, prr_pkg::BPP_8, 1'b1, 1'b0);
    cmp_b(sact, 1'b0);
    frame(1'b0, prr_pkg::PCS_DIV2, 8'h00, 17'h002ef, prr_pkg::BPP_8, 1'b1, 1'b1);
    frame(1'b1, prr_pkg::PCS_DIV1, 8'ha0, 17'h0009f, prr_pkg::BPP_4, 1'b0, 1'b1);
    frame(1'b1, prr_pkg::PCS_DIV4, 8'ha0, 17'h00140, prr_pkg::BPP_2, 1'b0, 1'b0);
    frame(1'b0, prr_pkg::PCS_DIV8, 8'h10, 17'h00010, prr_pkg::BPP_1, 1'b0, 1'b0);
    en = 1'b0;
    repeat (4) @(negedge clk_in);
    cmp_b(sact, 1'b1);
    end_sim();
  end
endmodule
bind prr_refresh prr_refresh_sva chk (.clk_in, .rst_n_in, .rot_enable_in, .rot_select_in,
  .pclk_sel_in, .start_addr_in, .split_req_in, .frame_start_in, .mem_addr_out, .mem_rd_out,
  .pixel_valid_out, .pclk_en_out, .mclk_en_out, .split_active_out, .busy_out);
`default_nettype wire
